/* File: verilog/pwq_pkg.sv */
package pwq_pkg;

   // -------------------------------------------------------------------------
   // Widths
   // -------------------------------------------------------------------------
   localparam int unsigned AXI_AW = 12;
   localparam int unsigned THR_W  = 11;
   localparam int unsigned PROD_W = 22;
   localparam int unsigned CNT_W  = 24;
   localparam int unsigned NQ     = 4;
   localparam int unsigned QIDX_W = 2;
   localparam int unsigned VID_W  = 12;

   // -------------------------------------------------------------------------
   // Register offsets (byte addresses inside the port window)
   // -------------------------------------------------------------------------
   localparam logic [11:0] OFS_POLICE_CTRL = 12'h80C;
   localparam logic [11:0] OFS_PM_CTRL0    = 12'h830;
   localparam logic [11:0] OFS_PM_CTRL1    = 12'h834;
   localparam logic [11:0] OFS_Q_THR       = 12'h840;
   localparam logic [11:0] OFS_Q_MULT      = 12'h844;
   localparam logic [11:0] OFS_Q_PERF_MONITOR_COUNTERS      = 12'h848;
   localparam logic [11:0] OFS_TXQ_SEL     = 12'h900;
   localparam logic [11:0] OFS_VID_REP     = 12'h904;

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int unsigned HI_LSB       = 16;
   localparam int unsigned HI_MSB       = 26;
   localparam int unsigned LO_MSB       = 10;
   localparam int unsigned RND_EN_BIT   = 31;
   localparam int unsigned FLUSH_BIT    = 30;
   localparam int unsigned ALL_INH_BIT  = 29;
   localparam int unsigned YR_INH_BIT   = 28;
   localparam int unsigned R_INH_BIT    = 27;
   localparam int unsigned DROP_ALL_BIT = 26;
   localparam int unsigned CNT_MSB      = 23;
   localparam int unsigned QIDX_B3_LSB  = 24;
   localparam int unsigned POLICE_BIT   = 0;
   localparam int unsigned VID_REP_BIT  = 0;

   // -------------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------------
   localparam logic [10:0] PM_MAX_RST = 11'h400;
   localparam logic [10:0] PM_MIN_RST = 11'h080;
   localparam logic [10:0] PM_MUL_RST = 11'h020;
   localparam logic [10:0] Q_MAX_RST  = 11'h080;
   localparam logic [10:0] Q_MIN_RST  = 11'h009;
   localparam logic [10:0] Q_MUL_RST  = 11'h010;
   localparam logic [23:0] CNT_RST    = 24'h000000;
   localparam logic [1:0]  QIDX_RST   = 2'h0;

   // -------------------------------------------------------------------------
   // Bus answers and packet colours
   // -------------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PWQ_GREEN  = 2'h0,
      PWQ_YELLOW = 2'h1,
      PWQ_RED    = 2'h2
   } pwq_color_t;

endpackage

/* File: verilog/pwq_regs.sv */
// Behaviour
// - Packet-memory drop multiplier, 11 bits RW at 26:16, resets to 0x020.
// - Packet-memory average queue size readable at 10:0; writes ignored.
// - Per-queue maximum threshold at 26:16, reset 0x080, selected queue.
// - Per-queue minimum threshold at 10:0, reset 0x009, selected queue.
// - Per-queue drop multiplier at 26:16, reset 0x010, selected queue.
// - Selected queue average size readable at 10:0 of queue multiplier register.
// - Random dropping happens only while random-drop enable bit 31 is set.
// - Rising edge of bit 30 clears all event counters; levels do nothing.
// - Bit 29 set stops dropping of green, yellow and red packets.
// - Bit 28 set stops dropping of yellow and red packets.
// - Bit 27 set stops dropping of red packets.
// - Bit 26 set drops everything above queue maximum, else multiplier decides; above packet-memory maximum always drops.
// - Read-only 24-bit event counter at 23:0 per selected queue, reset zero.
// - Two-bit queue index at 1:0, reset 0, steers indexed registers.
// - Queue index also writable as a byte at byte address 0x903.
// - Replacement bit set swaps nonzero egress VLAN ID for port default.
// - With double tagging, replacement acts on the outer tag instead.
// - Packet-memory max and min thresholds, reset 0x400 and 0x080.
// - Random dropping needs the policing enable bit set as well.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pwq_regs (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // AXI4-Lite slave
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Queue occupancy from the queue manager
   input  wire logic [10:0]          pm_avg_size,
   input  wire logic [43:0]          q_avg_size,
   // Drop decision request
   input  wire logic                 pkt_valid,
   input  wire logic [1:0]           pkt_queue,
   input  wire pwq_pkg::pwq_color_t  pkt_color,
   input  wire logic [21:0]          pkt_rand,
   output logic                      drop_valid,
   output logic                      drop,
   // Egress VLAN path
   input  wire logic                 egr_valid,
   input  wire logic                 double_tag_en,
   input  wire logic [11:0]          egr_vid,
   input  wire logic [11:0]          egr_outer_vid,
   input  wire logic [11:0]          port_default_vlan_id,
   output logic                      egr_out_valid,
   output logic [11:0]               egr_vid_out,
   output logic [11:0]               egr_outer_vid_out
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [10:0]            pm_max;
      logic [10:0]            pm_min;
      logic [10:0]            pm_mult;
      logic [3:0][10:0]       q_max;
      logic [3:0][10:0]       q_min;
      logic [3:0][10:0]       q_mult;
      logic                   rnd_en;
      logic                   flush;
      logic                   flush_prev;
      logic                   all_color_drop_inhibit;
      logic                   yellow_red_drop_inhibit;
      logic                   red_inh;
      logic                   drop_all;
      logic [3:0][23:0]       cnt;
      logic [1:0]             qidx;
      logic                   vid_rep;
      logic                   police_en;
      logic                   aw_got;
      logic [11:0]            awaddr;
      logic                   w_got;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [31:0]            rdata;
      logic                   drop_valid;
      logic                   drop;
      logic                   egr_valid;
      logic [11:0]            vid;
      logic [11:0]            outer_vid;
   } pwq_state_t;

   pwq_state_t st_q;
   pwq_state_t st_d;
   pwq_state_t st_rst;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------

   // Byte-lane merge of a write into the current register image
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Weighted early drop test; product kept at full width so nothing wraps
   function automatic logic wred(input logic [10:0] avg,
                                 input logic [10:0] mn,
                                 input logic [10:0] mx,
                                 input logic [10:0] mult,
                                 input logic        all,
                                 input logic [21:0] rnd);
      logic [21:0] prod;
      logic        hit;
      prod = 22'(avg - mn) * 22'(mult);
      hit  = 1'b0;
      if (avg < mn) begin
         hit = 1'b0;
      end else if (avg > mx && all) begin
         hit = 1'b1;
      end else begin
         hit = rnd < prod;
      end
      return hit;
   endfunction

   // Register image as software reads it, with a decode-miss flag
   function automatic logic [32:0] rd_image(input pwq_state_t s,
                                            input logic [11:0] a,
                                            input logic [43:0] qavg,
                                            input logic [10:0] pmavg);
      logic [31:0] v;
      logic        miss;
      v    = 32'h00000000;
      miss = 1'b0;
      case ({a[11:2], 2'h0})                      // Byte offsets share their word
         pwq_pkg::OFS_POLICE_CTRL: begin
            v[pwq_pkg::POLICE_BIT] = s.police_en;
         end
         pwq_pkg::OFS_PM_CTRL0: begin
            v[pwq_pkg::HI_MSB:pwq_pkg::HI_LSB] = s.pm_max;
            v[pwq_pkg::LO_MSB:0]               = s.pm_min;
         end
         pwq_pkg::OFS_PM_CTRL1: begin
            v[pwq_pkg::HI_MSB:pwq_pkg::HI_LSB] = s.pm_mult;
            v[pwq_pkg::LO_MSB:0]               = pmavg;
         end
         pwq_pkg::OFS_Q_THR: begin
            v[pwq_pkg::HI_MSB:pwq_pkg::HI_LSB] = s.q_max[s.qidx];
            v[pwq_pkg::LO_MSB:0]               = s.q_min[s.qidx];
         end
         pwq_pkg::OFS_Q_MULT: begin
            v[pwq_pkg::HI_MSB:pwq_pkg::HI_LSB] = s.q_mult[s.qidx];
            v[pwq_pkg::LO_MSB:0] = qavg[s.qidx*pwq_pkg::THR_W +: 11];
         end
         pwq_pkg::OFS_Q_PERF_MONITOR_COUNTERS: begin
            v[pwq_pkg::RND_EN_BIT]   = s.rnd_en;
            v[pwq_pkg::FLUSH_BIT]    = s.flush;
            v[pwq_pkg::ALL_INH_BIT]  = s.all_color_drop_inhibit;
            v[pwq_pkg::YR_INH_BIT]   = s.yellow_red_drop_inhibit;
            v[pwq_pkg::R_INH_BIT]    = s.red_inh;
            v[pwq_pkg::DROP_ALL_BIT] = s.drop_all;
            v[pwq_pkg::CNT_MSB:0]    = s.cnt[s.qidx];
         end
         pwq_pkg::OFS_TXQ_SEL: begin
            v[1:0] = s.qidx;
            v[pwq_pkg::QIDX_B3_LSB +: 2] = s.qidx;
         end
         pwq_pkg::OFS_VID_REP: begin
            v[pwq_pkg::VID_REP_BIT] = s.vid_rep;
         end
         default: begin
            miss = 1'b1;
         end
      endcase
      return {miss, v};
   endfunction

   // -------------------------------------------------------------------------
   // Reset image
   // -------------------------------------------------------------------------
   always_comb begin
      st_rst         = '0;
      st_rst.pm_max  = pwq_pkg::PM_MAX_RST;
      st_rst.pm_min  = pwq_pkg::PM_MIN_RST;
      st_rst.pm_mult = pwq_pkg::PM_MUL_RST;
      for (int q = 0; q < pwq_pkg::NQ; q++) begin
         st_rst.q_max[q]  = pwq_pkg::Q_MAX_RST;
         st_rst.q_min[q]  = pwq_pkg::Q_MIN_RST;
         st_rst.q_mult[q] = pwq_pkg::Q_MUL_RST;
         st_rst.cnt[q]    = pwq_pkg::CNT_RST;
      end
      st_rst.qidx  = pwq_pkg::QIDX_RST;
      st_rst.bresp = pwq_pkg::RESP_OKAY;
      st_rst.rresp = pwq_pkg::RESP_OKAY;
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      logic [32:0] img;
      logic [31:0] m;
      logic        do_wr;
      logic        inhibit;
      logic        hit;
      logic        flush_edge;
      logic [10:0] qa;
      img        = '0;
      m          = '0;
      do_wr      = 1'b0;
      inhibit    = 1'b0;
      hit        = 1'b0;
      flush_edge = 1'b0;
      qa         = '0;
      st_d       = st_q;

      // Write channels: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end

      // Commit once both halves are held; the response follows the write
      do_wr = st_q.aw_got && st_q.w_got && !st_q.bvalid;
      if (do_wr) begin
         img          = rd_image(st_q, st_q.awaddr, q_avg_size, pm_avg_size);
         m            = merge(img[31:0], st_q.wdata, st_q.wstrb);
         st_d.aw_got  = 1'b0;
         st_d.w_got   = 1'b0;
         st_d.bvalid  = 1'b1;
         st_d.bresp   = img[32] ? pwq_pkg::RESP_SLVERR : pwq_pkg::RESP_OKAY;
         // Low address bits dropped so a byte write at 0x903 still finds the index
         case ({st_q.awaddr[11:2], 2'h0})
            pwq_pkg::OFS_POLICE_CTRL: begin
               st_d.police_en = m[pwq_pkg::POLICE_BIT];
            end
            pwq_pkg::OFS_PM_CTRL0: begin
               st_d.pm_max = m[pwq_pkg::HI_MSB:pwq_pkg::HI_LSB];
               st_d.pm_min = m[pwq_pkg::LO_MSB:0];
            end
            pwq_pkg::OFS_PM_CTRL1: begin
               // Average field is driven by the queue manager, never stored
               st_d.pm_mult = m[pwq_pkg::HI_MSB:pwq_pkg::HI_LSB];
            end
            pwq_pkg::OFS_Q_THR: begin
               st_d.q_max[st_q.qidx] = m[pwq_pkg::HI_MSB:pwq_pkg::HI_LSB];
               st_d.q_min[st_q.qidx] = m[pwq_pkg::LO_MSB:0];
            end
            pwq_pkg::OFS_Q_MULT: begin
               st_d.q_mult[st_q.qidx] = m[pwq_pkg::HI_MSB:pwq_pkg::HI_LSB];
            end
            pwq_pkg::OFS_Q_PERF_MONITOR_COUNTERS: begin
               st_d.rnd_en                  = m[pwq_pkg::RND_EN_BIT];
               st_d.flush                   = m[pwq_pkg::FLUSH_BIT];
               st_d.all_color_drop_inhibit  = m[pwq_pkg::ALL_INH_BIT];
               st_d.yellow_red_drop_inhibit = m[pwq_pkg::YR_INH_BIT];
               st_d.red_inh                 = m[pwq_pkg::R_INH_BIT];
               st_d.drop_all                = m[pwq_pkg::DROP_ALL_BIT];
            end
            pwq_pkg::OFS_TXQ_SEL: begin
               // Byte lane 3 is the 8-bit alias; it wins if both lanes write
               if (st_q.wstrb[0]) begin
                  st_d.qidx = st_q.wdata[1:0];
               end
               if (st_q.wstrb[3]) begin
                  st_d.qidx = st_q.wdata[pwq_pkg::QIDX_B3_LSB +: 2];
               end
            end
            pwq_pkg::OFS_VID_REP: begin
               st_d.vid_rep = m[pwq_pkg::VID_REP_BIT];
            end
            default: begin
               st_d.bresp = pwq_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Read channel: data answered one cycle after the address is taken
      if (s_axi_rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         img         = rd_image(st_q, s_axi_araddr, q_avg_size, pm_avg_size);
         st_d.rvalid = 1'b1;
         st_d.rdata  = img[31:0];
         st_d.rresp  = img[32] ? pwq_pkg::RESP_SLVERR : pwq_pkg::RESP_OKAY;
      end

      // Drop decision, answered one cycle after the request
      case (pkt_color)
         pwq_pkg::PWQ_GREEN:  inhibit = st_q.all_color_drop_inhibit;
         pwq_pkg::PWQ_YELLOW: inhibit = st_q.all_color_drop_inhibit |
                                        st_q.yellow_red_drop_inhibit;
         pwq_pkg::PWQ_RED:    inhibit = st_q.all_color_drop_inhibit |
                                        st_q.yellow_red_drop_inhibit |
                                        st_q.red_inh;
         default:             inhibit = st_q.all_color_drop_inhibit;
      endcase
      qa  = q_avg_size[pkt_queue*pwq_pkg::THR_W +: 11];
      hit = wred(qa, st_q.q_min[pkt_queue], st_q.q_max[pkt_queue],
                 st_q.q_mult[pkt_queue], st_q.drop_all, pkt_rand) ||
            wred(pm_avg_size, st_q.pm_min, st_q.pm_max, st_q.pm_mult,
                 1'b1, pkt_rand);
      st_d.drop_valid = pkt_valid;
      st_d.drop       = pkt_valid && hit && !inhibit &&
                        st_q.rnd_en &&
                        st_q.police_en;

      // Event counters: flush on the 0-to-1 transition only; flush beats count
      st_d.flush_prev = st_q.flush;
      flush_edge      = st_q.flush && !st_q.flush_prev;
      for (int q = 0; q < pwq_pkg::NQ; q++) begin
         if (flush_edge) begin
            st_d.cnt[q] = pwq_pkg::CNT_RST;
         end else if (st_d.drop && pkt_queue == 2'(q)) begin
            st_d.cnt[q] = st_q.cnt[q] + 24'h000001;
         end
      end

      // Egress VLAN replacement; a zero ID is priority-tagged and left alone
      st_d.egr_valid = egr_valid;
      st_d.vid       = egr_vid;
      st_d.outer_vid = egr_outer_vid;
      if (egr_valid && st_q.vid_rep) begin
         if (double_tag_en) begin
            if (egr_outer_vid != 12'h000) begin
               st_d.outer_vid = port_default_vlan_id;
            end
         end else if (egr_vid != 12'h000) begin
            st_d.vid = port_default_vlan_id;
         end
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= st_rst;
      end else begin
         st_q <= st_d;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   // Ready held low while a half is parked, so one write is in flight at most
   assign s_axi_awready     = !st_q.aw_got && !st_q.bvalid;
   assign s_axi_wready      = !st_q.w_got && !st_q.bvalid;
   assign s_axi_bvalid      = st_q.bvalid;
   assign s_axi_bresp       = st_q.bresp;
   assign s_axi_arready     = !st_q.rvalid;
   assign s_axi_rvalid      = st_q.rvalid;
   assign s_axi_rdata       = st_q.rdata;
   assign s_axi_rresp       = st_q.rresp;
   assign drop_valid        = st_q.drop_valid;
   assign drop              = st_q.drop;
   assign egr_out_valid     = st_q.egr_valid;
   assign egr_vid_out       = st_q.vid;
   assign egr_outer_vid_out = st_q.outer_vid;

endmodule

/* File: test/pwq_props.sv */
`timescale 1ns/10ps
// Handshake and sideband timing seen at the block's own pins
module pwq_props (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        pkt_valid,
   input wire logic        drop_valid,
   input wire logic        drop,
   input wire logic        egr_valid,
   input wire logic        egr_out_valid
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // A lost answer would hang the master, so read, drop and egress answers are bounded; the write response is only held
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped early");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar early");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_drop_pulse: assert property (pkt_valid |=> drop_valid) else $error("no decision");
   a_drop_idle: assert property (!pkt_valid |=> !drop_valid && !drop) else $error("stray");
   a_drop_qual: assert property (drop |-> drop_valid) else $error("drop without valid");
   a_egr_delay: assert property (egr_valid |=> egr_out_valid) else $error("egress lost");
   cover property (drop);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind pwq_regs pwq_props pwq_props_i (.clk, .rst_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .pkt_valid, .drop_valid, .drop,
   .egr_valid, .egr_out_valid);

/* File: test/pwq_regs_tb_top.sv */
`timescale 1ns/10ps
module pwq_regs_tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, p, tg;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        pkt_valid = 1'b0, egr_valid = 1'b0, double_tag_en = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        drop_valid, drop, egr_out_valid;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0, egr_vid = '0, egr_outer_vid = '0, vi, vo;
   logic [11:0] port_default_vlan_id = 12'h5A3, egr_vid_out, egr_outer_vid_out;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, c, ex, th [4];
   logic [10:0] pm_avg_size = '0, qa [4], qv;
   logic [43:0] q_avg_size = '0;
   logic [21:0] pkt_rand = '0, pr;
   logic [3:0]  s_axi_wstrb = '0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, pkt_queue = '0, r, k, u;
   pwq_pkg::pwq_color_t pkt_color = pwq_pkg::PWQ_GREEN;
   int          fails = 0, n_tests = 0, cyc = 0, nd [4] = '{0, 0, 0, 0};

   pwq_regs pwq_regs_i (.*);

   always #5 clk = ~clk;

   // Hang guard, far above what the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests = n_tests + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Both write halves go up together; each drops only at the edge that takes it
   task automatic wr(input logic [11:0] a, input logic [31:0] w, input logic [3:0] s);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // Read a word and compare it
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
   endtask

   // Every queue has min 0x010, max 0x020, multiplier 0x010; average a is swept across them
   function automatic logic ed(input logic [31:0] c, input logic p, input logic [1:0] k,
                               input logic [21:0] pr, input logic [10:0] a);
      return p & c[31] & (a >= 11'h010)
             & ((c[26] & (a > 11'h020)) | (pr < 22'(a - 11'h010) * 22'h10))
             & !c[29] & !(c[28] & (k != 2'h0)) & !(c[27] & (k == 2'h2));
   endfunction

   initial begin
      void'($urandom(68));
      for (int q = 0; q < 4; q++) begin
         qa[q] = 11'($urandom);
         th[q] = $urandom & 32'h07FF_07FF;
      end
      pm_avg_size <= 11'($urandom % 128);
      q_avg_size <= {qa[3], qa[2], qa[1], qa[0]};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rc(12'h830, 32'h0400_0080);
      rc(12'h834, {16'h0020, 5'h0, pm_avg_size});
      rc(12'h840, 32'h0080_0009);
      rc(12'h844, {16'h0010, 5'h0, qa[0]});
      rc(12'h848, 32'h0);
      rc(12'h900, 32'h0);
      rc(12'h904, 32'h0);
      rc(12'h850, 32'h0);
      chk(32'(r), 32'(pwq_pkg::RESP_SLVERR));
      wr(12'h850, 32'hFFFF_FFFF, 4'hF);
      chk(32'(r), 32'(pwq_pkg::RESP_SLVERR));
      wr(12'h834, 32'hFFFF_FFFF, 4'hF);
      rc(12'h834, {5'h0, 11'h7FF, 5'h0, pm_avg_size});
      // Odd passes use the byte alias at its own byte address
      for (int j = 0; j < 8; j++) begin
         wr(j[0] ? 12'h903 : 12'h900, j[0] ? {6'h0, j[1:0], 24'h0} : 32'(j % 4),
            j[0] ? 4'h8 : 4'h1);
         rc(12'h900, {6'h0, j[1:0], 22'h0, j[1:0]});
         if (j < 4) wr(12'h840, th[j] | 32'hF800_F800, 4'hF);
         else rc(12'h840, th[j % 4]);
         rc(12'h844, {16'h0010, 5'h0, qa[j % 4]});
      end
      for (int q = 0; q < 4; q++) begin
         wr(12'h900, 32'(q), 4'h1);
         wr(12'h840, 32'h0020_0010, 4'hF);
      end
      for (int j = 0; j < 48; j++) begin
         c = $urandom & 32'hBC00_0000;
         p = 1'($urandom);
         k = 2'($urandom % 3);
         u = 2'($urandom);
         qv = 11'($urandom % 64);
         pr = 22'($urandom & 32'h3FF);
         wr(12'h80C, 32'(p), 4'hF);
         wr(12'h848, c, 4'hF);
         @(posedge clk);
         pkt_color <= pwq_pkg::pwq_color_t'(k);
         pkt_queue <= u;
         q_avg_size <= {4{qv}};
         pkt_rand <= pr;
         pkt_valid <= 1'b1;
         @(posedge clk);
         pkt_valid <= 1'b0;
         @(posedge clk);
         ex = 32'({1'b1, ed(c, p, k, pr, qv)});
         chk(32'({drop_valid, drop}), ex);
         nd[u] = nd[u] + int'(ex[0]);
      end
      for (int q = 0; q < 4; q++) begin
         wr(12'h900, 32'(q), 4'h1);
         rc(12'h848, c | 32'(nd[q]));
      end
      wr(12'h848, c | 32'h4000_0000, 4'hF);
      rc(12'h848, c | 32'h4000_0000);
      wr(12'h80C, 32'h1, 4'hF);
      wr(12'h848, 32'hC400_0000, 4'hF);
      @(posedge clk);
      pkt_queue <= 2'h3;
      q_avg_size <= {4{11'h030}};
      pkt_valid <= 1'b1;
      @(posedge clk);
      pkt_valid <= 1'b0;
      rc(12'h848, 32'hC400_0001);
      // Replacement on for the first half, off for the second
      for (int j = 0; j < 32; j++) begin
         if (j % 16 == 0) wr(12'h904, 32'(j == 0), 4'hF);
         vi = 12'(($urandom % 3 == 0) ? 0 : $urandom);
         vo = 12'(($urandom % 3 == 0) ? 0 : $urandom);
         tg = 1'($urandom);
         ex = {7'h0, 1'b1, (j < 16 && !tg && vi != 0) ? port_default_vlan_id : vi,
               (j < 16 && tg && vo != 0) ? port_default_vlan_id : vo};
         @(posedge clk);
         egr_vid <= vi;
         egr_outer_vid <= vo;
         double_tag_en <= tg;
         egr_valid <= 1'b1;
         repeat (2) @(posedge clk);
         chk({7'h0, egr_out_valid, egr_vid_out, egr_outer_vid_out}, ex);
      end
      print_verdict();
   end
endmodule
